// file: inc/ets_consts.svh
`ifndef ETS_CONSTS_SVH
`define ETS_CONSTS_SVH
`define ETS_ADDR_CTRL 4'h0
`define ETS_ADDR_ENA_PAT 4'h1
`define ETS_ADDR_TRG_PAT 4'h2
`define ETS_ADDR_CHSEL 4'h3
`define ETS_ADDR_DELAY 4'h4
`define ETS_ADDR_STATUS 4'h5
`define ETS_ADDR_CMD 4'h6
`define ETS_CTRL_EMODE_LSB 0
`define ETS_CTRL_EFALSE 2
`define ETS_CTRL_TMODE_LSB 3
`define ETS_CTRL_TFALSE 5
`define ETS_CTRL_FILTER 6
`define ETS_CTRL_ANALOG 7
`define ETS_PAT_CARE_LSB 0
`define ETS_PAT_VAL_LSB 16
`define ETS_DELAY_EVT 16
`define ETS_CMD_ARM 0
`define ETS_CMD_MAN_EN 1
`define ETS_CMD_MAN_TRG 2
`define ETS_ST_EN_BIT 0
`define ETS_ST_TRG_BIT 1
`define ETS_ST_DLY_BIT 2
`define ETS_ST_DONE_BIT 3
`define ETS_ST_EMODE_LSB 4
`define ETS_ST_TMODE_LSB 6
`define ETS_ST_CNT_LSB 16
`define ETS_CHSEL_RST 8'hFF
`define ETS_PAT_RST 9'h000
`define ETS_DELAY_RST 16'h0000
`define ETS_DELAY_MAX 16'hFDE8
`define ETS_ANALOG_MASK 8'hF0
`define ETS_ADC_MSB 3
`define ETS_FILTER_LEN 3
`define ETS_CLK_NS 40
`define ETS_LATCH_NS 2
`define ETS_LATCH_CYC ((`ETS_LATCH_NS + `ETS_CLK_NS - 1) / `ETS_CLK_NS)
`endif

// file: inc/ets_pkg.sv
package ets_pkg;
  typedef enum {
    ETS_IDLE,
    ETS_WAIT_EN,
    ETS_WAIT_TRG,
    ETS_DELAY,
    ETS_DONE
  } ets_state_t;
  typedef enum logic [1:0] {
    ETS_EN_AUTO,
    ETS_EN_MANUAL,
    ETS_EN_COMB
  } ets_emode_t;
  typedef enum logic [1:0] {
    ETS_TRG_AUTO,
    ETS_TRG_MANUAL,
    ETS_TRG_COMB,
    ETS_TRG_ANALOG
  } ets_tmode_t;
endpackage : ets_pkg

// file: hdl/ets_sequencer.sv
// The plain strobed port and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps
`include "ets_consts.svh"
// Notes on behaviour
// - After arming, an enable event on the 9-bit word precedes trigger search.
// - Automatic enable skips the enable stage straight after arming.
// - Manual enable ignores the inputs and waits for the manual command.
// - Writing a new enable pattern selects combinational enable.
// - Each pattern bit is one, zero or don't-care; don't-care is ignored.
// - Manual enable forces the event while awaiting combinational enable.
// - After such an override the enable mode stays manual until reselected.
// - True enable fires on a match; status moves to trigger wait.
// - False enable finds the pattern, then fires when a compared bit changes.
// - Enable and trigger patterns each carry their own qualifier bit.
// - Manual trigger ignores the pattern and waits for the manual trigger.
// - Automatic trigger fires at once after the enable stage.
// - Combinational trigger matches eight channel bits plus the qualifier.
// - Deselected channels take no part in trigger matching.
// - Unfiltered triggering accepts a pattern seen on a single sample.
// - Filter on needs three consecutive matching samples; off needs one.
// - True trigger fires on match rising; false trigger on match falling.
// - Analog trigger fires on converter MSB rising (true) or falling.
// - After trigger, recording runs up to 65000 clocks or events more.
// - In analog use only channel bits 4 to 7 are matched.
module ets_sequencer
  import ets_pkg::*;
#(
  parameter int DELAY_W = 16
)
(
  input wire logic clk,
  input wire logic reset_n,
  input wire logic [3:0] addr,
  input wire logic [31:0] wr_data,
  input wire logic wr_en,
  input wire logic rd_en,
  output logic [31:0] rd_data,
  input wire logic [7:0] probe_data,
  input wire logic pattern_qualifier_bit,
  input wire logic [3:0] adc_data,
  output logic awaiting_enable,
  output logic awaiting_trigger_indication,
  output logic delaying,
  output logic record_done
);

  ////////////////////////////////////////////////////////////////////////////
  // Decoding helpers.

  function automatic logic pat_match(
    input logic [8:0] d,
    input logic [8:0] care,
    input logic [8:0] val,
    input logic [8:0] mask
  );
    pat_match = &(~(care & mask) | ~(d ^ val));
  endfunction : pat_match

  function automatic ets_emode_t to_emode(input logic [1:0] v);
    if (v == 2'h1)
    begin
      to_emode = ETS_EN_MANUAL;
    end
    else if (v == 2'h2)
    begin
      to_emode = ETS_EN_COMB;
    end
    else
    begin
      to_emode = ETS_EN_AUTO;
    end
  endfunction : to_emode

  ////////////////////////////////////////////////////////////////////////////
  // Declarations.

  ets_emode_t emode_r;
  ets_tmode_t tmode_r;
  logic efalse_r;
  logic tfalse_r;
  logic filter_r;
  logic analog_r;
  logic [8:0] ecare_r;
  logic [8:0] eval_r;
  logic [8:0] tcare_r;
  logic [8:0] tval_r;
  logic [7:0] chsel_r;
  logic [DELAY_W-1:0] dly_r;
  logic dly_evt_r;
  ets_state_t state_r;
  ets_state_t state_nxt;
  logic [DELAY_W-1:0] cnt_r;
  logic eseen_r;
  logic tprev_r;
  logic aprev_r;
  logic [1:0] run_r;
  logic [31:0] rd_data_r;
  logic awaiting_enable_r;
  logic awaiting_trigger_r;
  logic delaying_r;
  logic record_done_r;
  logic wr_ctrl;
  logic wr_epat;
  logic wr_tpat;
  logic wr_cmd;
  logic arm;
  logic man_en;
  logic man_trg;
  logic [8:0] sample;
  logic [8:0] mask;
  logic ematch;
  logic tmatch_raw;
  logic tmatch;
  logic [1:0] need;
  logic tedge;
  logic aedge;
  logic en_event;
  logic trg_event;
  logic dly_tick;

  ////////////////////////////////////////////////////////////////////////////
  // Register writes and commands.

  assign wr_ctrl = wr_en && (addr == `ETS_ADDR_CTRL);
  assign wr_epat = wr_en && (addr == `ETS_ADDR_ENA_PAT);
  assign wr_tpat = wr_en && (addr == `ETS_ADDR_TRG_PAT);
  assign wr_cmd = wr_en && (addr == `ETS_ADDR_CMD);
  assign arm = wr_cmd && wr_data[`ETS_CMD_ARM];
  assign man_en = wr_cmd && wr_data[`ETS_CMD_MAN_EN];
  assign man_trg = wr_cmd && wr_data[`ETS_CMD_MAN_TRG];

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      emode_r <= ETS_EN_AUTO;
    end
    else if (wr_epat)
    begin
      emode_r <= ETS_EN_COMB;
    end
    else if (wr_ctrl)
    begin
      emode_r <= to_emode(wr_data[`ETS_CTRL_EMODE_LSB +: 2]);
    end
    else if (state_r == ETS_WAIT_EN && emode_r == ETS_EN_COMB && man_en)
    begin
      emode_r <= ETS_EN_MANUAL;
    end
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      tmode_r <= ETS_TRG_AUTO;
      efalse_r <= 1'b0;
      tfalse_r <= 1'b0;
      filter_r <= 1'b0;
      analog_r <= 1'b0;
    end
    else if (wr_ctrl)
    begin
      tmode_r <= ets_tmode_t'(wr_data[`ETS_CTRL_TMODE_LSB +: 2]);
      efalse_r <= wr_data[`ETS_CTRL_EFALSE];
      tfalse_r <= wr_data[`ETS_CTRL_TFALSE];
      filter_r <= wr_data[`ETS_CTRL_FILTER];
      analog_r <= wr_data[`ETS_CTRL_ANALOG];
    end
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      ecare_r <= `ETS_PAT_RST;
      eval_r <= `ETS_PAT_RST;
    end
    else if (wr_epat)
    begin
      ecare_r <= wr_data[`ETS_PAT_CARE_LSB +: 9];
      eval_r <= wr_data[`ETS_PAT_VAL_LSB +: 9];
    end
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      tcare_r <= `ETS_PAT_RST;
      tval_r <= `ETS_PAT_RST;
    end
    else if (wr_tpat)
    begin
      tcare_r <= wr_data[`ETS_PAT_CARE_LSB +: 9];
      tval_r <= wr_data[`ETS_PAT_VAL_LSB +: 9];
    end
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      chsel_r <= `ETS_CHSEL_RST;
    end
    else if (wr_en && addr == `ETS_ADDR_CHSEL)
    begin
      chsel_r <= wr_data[7:0];
    end
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      dly_r <= DELAY_W'(`ETS_DELAY_RST);
      dly_evt_r <= 1'b0;
    end
    else if (wr_en && addr == `ETS_ADDR_DELAY)
    begin
      if (wr_data[DELAY_W-1:0] > DELAY_W'(`ETS_DELAY_MAX))
      begin
        dly_r <= DELAY_W'(`ETS_DELAY_MAX);
      end
      else
      begin
        dly_r <= wr_data[DELAY_W-1:0];
      end
      dly_evt_r <= wr_data[`ETS_DELAY_EVT];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pattern matching and edge detection.

  assign sample = {pattern_qualifier_bit, probe_data};
  // Analog use gives bits 0 to 3 to the converter.
  assign mask = {1'b1, chsel_r & ((analog_r || tmode_r == ETS_TRG_ANALOG)
    ? `ETS_ANALOG_MASK : 8'hFF)};
  assign ematch = pat_match(sample, ecare_r, eval_r, mask);
  assign tmatch_raw = pat_match(sample, tcare_r, tval_r, mask);
  assign need = filter_r ? 2'(`ETS_FILTER_LEN - 1)
    : 2'(`ETS_LATCH_CYC - 1);
  assign tmatch = tmatch_raw && (run_r >= need);
  assign tedge = tfalse_r ? (tprev_r && !tmatch)
    : (!tprev_r && tmatch);
  assign aedge = tfalse_r ? (aprev_r && !adc_data[`ETS_ADC_MSB])
    : (!aprev_r && adc_data[`ETS_ADC_MSB]);

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      run_r <= 2'h0;
    end
    else if (!tmatch_raw)
    begin
      run_r <= 2'h0;
    end
    else if (run_r != 2'h3)
    begin
      run_r <= run_r + 2'h1;
    end
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      tprev_r <= 1'b0;
      aprev_r <= 1'b0;
    end
    else
    begin
      tprev_r <= tmatch;
      aprev_r <= adc_data[`ETS_ADC_MSB];
    end
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      eseen_r <= 1'b0;
    end
    else if (arm || state_r != ETS_WAIT_EN)
    begin
      eseen_r <= 1'b0;
    end
    else if (ematch)
    begin
      eseen_r <= 1'b1;
    end
  end

  always_comb
  begin
    en_event = 1'b0;
    case (emode_r)
      ETS_EN_AUTO: en_event = 1'b1;
      ETS_EN_MANUAL: en_event = man_en;
      // A manual command completes a stalled combinational search.
      ETS_EN_COMB: en_event = man_en || (efalse_r
        ? (eseen_r && !ematch) : ematch);
      default: en_event = 1'b0;
    endcase
  end

  always_comb
  begin
    trg_event = 1'b0;
    case (tmode_r)
      ETS_TRG_AUTO: trg_event = 1'b1;
      ETS_TRG_MANUAL: trg_event = man_trg;
      ETS_TRG_COMB: trg_event = tedge;
      ETS_TRG_ANALOG: trg_event = aedge;
      default: trg_event = 1'b0;
    endcase
  end

  assign dly_tick = !dly_evt_r || (tmode_r == ETS_TRG_AUTO)
    || trg_event;

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer.

  always_comb
  begin
    state_nxt = state_r;
    if (arm)
    begin
      state_nxt = (emode_r == ETS_EN_AUTO) ? ETS_WAIT_TRG
        : ETS_WAIT_EN;
    end
    else
    begin
      case (state_r)
        ETS_WAIT_EN:
          if (en_event)
          begin
            state_nxt = ETS_WAIT_TRG;
          end
        ETS_WAIT_TRG:
          if (trg_event)
          begin
            state_nxt = ETS_DELAY;
          end
        ETS_DELAY:
          if (cnt_r == '0)
          begin
            state_nxt = ETS_DONE;
          end
        default: state_nxt = state_r;
      endcase
    end
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      state_r <= ETS_IDLE;
    end
    else
    begin
      state_r <= state_nxt;
    end
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      cnt_r <= '0;
    end
    else if (state_r == ETS_WAIT_TRG && state_nxt == ETS_DELAY)
    begin
      cnt_r <= dly_r;
    end
    else if (state_r == ETS_DELAY && cnt_r != '0 && dly_tick)
    begin
      cnt_r <= cnt_r - DELAY_W'(1);
    end
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      awaiting_enable_r <= 1'b0;
      awaiting_trigger_r <= 1'b0;
      delaying_r <= 1'b0;
      record_done_r <= 1'b0;
    end
    else
    begin
      awaiting_enable_r <= state_nxt == ETS_WAIT_EN;
      awaiting_trigger_r <= state_nxt == ETS_WAIT_TRG;
      delaying_r <= state_nxt == ETS_DELAY;
      record_done_r <= state_nxt == ETS_DONE;
    end
  end

  assign awaiting_enable = awaiting_enable_r;
  assign awaiting_trigger_indication = awaiting_trigger_r;
  assign delaying = delaying_r;
  assign record_done = record_done_r;

  ////////////////////////////////////////////////////////////////////////////
  // Register reads.

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      rd_data_r <= 32'h0;
    end
    else if (!rd_en)
    begin
      rd_data_r <= 32'h0;
    end
    else if (addr == `ETS_ADDR_CTRL)
    begin
      rd_data_r <= {24'h0, analog_r, filter_r, tfalse_r, tmode_r,
        efalse_r, emode_r};
    end
    else if (addr == `ETS_ADDR_ENA_PAT)
    begin
      rd_data_r <= {7'h0, eval_r, 7'h0, ecare_r};
    end
    else if (addr == `ETS_ADDR_TRG_PAT)
    begin
      rd_data_r <= {7'h0, tval_r, 7'h0, tcare_r};
    end
    else if (addr == `ETS_ADDR_CHSEL)
    begin
      rd_data_r <= {24'h0, chsel_r};
    end
    else if (addr == `ETS_ADDR_DELAY)
    begin
      rd_data_r <= 32'({dly_evt_r, 16'(dly_r)});
    end
    else if (addr == `ETS_ADDR_STATUS)
    begin
      rd_data_r <= {16'(cnt_r), 8'h0, tmode_r, emode_r, record_done_r,
        delaying_r, awaiting_trigger_r, awaiting_enable_r};
    end
    else
    begin
      rd_data_r <= 32'h0;
    end
  end

  assign rd_data = rd_data_r;

  ////////////////////////////////////////////////////////////////////////////
  // Checks.

  chk_auto_enable_skip: assert property (@(posedge clk) disable iff (!reset_n)
    arm && emode_r == ETS_EN_AUTO |=> awaiting_trigger_indication)
    else $error("Automatic enable did not skip the enable stage.");

  chk_load_selects_comb: assert property (@(posedge clk) disable iff (!reset_n)
    wr_epat |=> emode_r == ETS_EN_COMB)
    else $error("Enable pattern load did not select combinational.");

  chk_manual_override: assert property (@(posedge clk) disable iff (!reset_n)
    state_r == ETS_WAIT_EN && emode_r == ETS_EN_COMB && man_en && !arm
    && !wr_epat && !wr_ctrl
    |=> emode_r == ETS_EN_MANUAL && state_r == ETS_WAIT_TRG)
    else $error("Manual override of combinational enable failed.");

  chk_status_change: assert property (@(posedge clk) disable iff (!reset_n)
    state_r == ETS_WAIT_EN && en_event && !arm
    |=> awaiting_trigger_indication && !awaiting_enable)
    else $error("Status did not move to awaiting trigger.");

  chk_manual_trig_wait: assert property (@(posedge clk) disable iff (!reset_n)
    state_r == ETS_WAIT_TRG && tmode_r == ETS_TRG_MANUAL && !man_trg && !arm
    |=> state_r == ETS_WAIT_TRG)
    else $error("Manual trigger mode left without a command.");

  chk_auto_trig_fire: assert property (@(posedge clk) disable iff (!reset_n)
    state_r == ETS_WAIT_TRG && tmode_r == ETS_TRG_AUTO && !arm
    |=> delaying)
    else $error("Automatic trigger did not fire at once.");

  chk_filter_three: assert property (@(posedge clk) disable iff (!reset_n)
    tmatch && filter_r
    |-> tmatch_raw && $past(tmatch_raw) && $past(tmatch_raw, 2))
    else $error("Filtered match without three matching samples.");

  chk_analog_rise: assert property (@(posedge clk) disable iff (!reset_n)
    state_r == ETS_WAIT_TRG && tmode_r == ETS_TRG_ANALOG && !tfalse_r
    && !arm && !adc_data[`ETS_ADC_MSB] ##1 adc_data[`ETS_ADC_MSB] && !arm
    |=> delaying)
    else $error("Analog rising MSB did not trigger.");

  chk_delay_clocks: assert property (@(posedge clk) disable iff (!reset_n)
    state_r == ETS_WAIT_TRG && state_nxt == ETS_DELAY && dly_r == 16'h0002
    && !dly_evt_r ##1 !arm [*3]
    |=> record_done)
    else $error("Clock delay did not end on time.");

  chk_arm_restart: assert property (@(posedge clk) disable iff (!reset_n)
    arm && emode_r != ETS_EN_AUTO |=> awaiting_enable && state_r == ETS_WAIT_EN)
    else $error("Arm did not return to awaiting enable.");

endmodule : ets_sequencer

// file: tb/ets_probe_model.sv
`timescale 1ns/1ps
// Probe inputs from the circuit under test: channels, qualifier and converter.
module ets_probe_model
(
  input wire logic clk,
  output logic [7:0] probe_data,
  output logic pattern_qualifier_bit,
  output logic [3:0] adc_data
);
  initial
  begin
    probe_data = 8'h00;
    pattern_qualifier_bit = 1'b0;
    adc_data = 4'h0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // The circuit changes its levels just after a sampling edge.
  task drive(input logic q, input logic [7:0] d, input logic [3:0] a);
    @(posedge clk);
    probe_data <= d;
    pattern_qualifier_bit <= q;
    adc_data <= a;
  endtask : drive
endmodule : ets_probe_model

// file: tb/tb_top.sv
`timescale 1ns/1ps
`include "ets_consts.svh"
module tb_top;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic [3:0] addr = 4'h0;
  logic [31:0] wr_data = 32'h0000_0000;
  logic wr_en = 1'b0;
  logic rd_en = 1'b0;
  logic [31:0] rd_data;
  logic [7:0] probe_data;
  logic pattern_qualifier_bit;
  logic [3:0] adc_data;
  logic awaiting_enable;
  logic awaiting_trigger_indication;
  logic delaying;
  logic record_done;
  logic [3:0] st;
  int n_mismatch = 0;
  int checks = 0;

  assign st = {record_done, delaying, awaiting_trigger_indication,
               awaiting_enable};

  always #20 clk = ~clk;

  ets_sequencer #(.DELAY_W(16)) DUT (
    .clk(clk),
    .reset_n(reset_n),
    .addr(addr),
    .wr_data(wr_data),
    .wr_en(wr_en),
    .rd_en(rd_en),
    .rd_data(rd_data),
    .probe_data(probe_data),
    .pattern_qualifier_bit(pattern_qualifier_bit),
    .adc_data(adc_data),
    .awaiting_enable(awaiting_enable),
    .awaiting_trigger_indication(awaiting_trigger_indication),
    .delaying(delaying),
    .record_done(record_done)
  );

  ets_probe_model PRB (
    .clk(clk),
    .probe_data(probe_data),
    .pattern_qualifier_bit(pattern_qualifier_bit),
    .adc_data(adc_data)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Register bus tasks and compare tasks.
  task complete_run;
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : complete_run

  task chk_rd(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e)
    begin
      n_mismatch++;
      $display("FAIL %s expected %h seen %h", nm, e, g);
    end
  endtask : chk_rd

  task chk_st(input string nm, input logic [3:0] e);
    #1;
    checks++;
    if (st !== e)
    begin
      n_mismatch++;
      $display("FAIL %s expected %b seen %b", nm, e, st);
    end
  endtask : chk_st

  task wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wr_data <= d;
    wr_en <= 1'b1;
    @(posedge clk);
    wr_en <= 1'b0;
  endtask : wr

  task rd(input logic [3:0] a, input logic [31:0] m, input logic [31:0] e,
          input string nm);
    @(posedge clk);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge clk);
    rd_en <= 1'b0;
    #1;
    chk_rd(nm, e, rd_data & m);
  endtask : rd

  task cmd(input int b);
    wr(`ETS_ADDR_CMD, 32'h0000_0001 << b);
  endtask : cmd

  task step(input int n);
    repeat (n) @(posedge clk);
  endtask : step

  task wait_st(input string nm, input logic [3:0] e, input int lim);
    int i;
    i = 0;
    #1;
    while (st !== e && i < lim)
    begin
      @(posedge clk);
      #1;
      i++;
    end
    chk_st(nm, e);
  endtask : wait_st

  ////////////////////////////////////////////////////////////////////////////
  // Watchdog.
  initial
  begin
    repeat (3000) @(posedge clk);
    n_mismatch++;
    $display("FAIL watchdog expected finish seen hang");
    complete_run();
  end

  ////////////////////////////////////////////////////////////////////////////
  // Tests.
  initial
  begin
    repeat (10) @(posedge clk);
    reset_n <= 1'b1;
    chk_st("status idle", 4'h0);
    rd(`ETS_ADDR_STATUS, 32'hFFFF_FFFF, 32'h0000_0000, "status reg");
    rd(`ETS_ADDR_CHSEL, 32'h0000_00FF, 32'h0000_00FF, "chsel reset");
    @(posedge clk);
    #1;
    chk_rd("read clears", 32'h0000_0000, rd_data);
    rd(4'hF, 32'hFFFF_FFFF, 32'h0000_0000, "unmapped");
    wr(`ETS_ADDR_DELAY, 32'h0000_FFFF);
    rd(`ETS_ADDR_DELAY, 32'h0001_FFFF, 32'h0000_FDE8, "delay clamp");
    $display("test reset done");

    wr(`ETS_ADDR_DELAY, 32'h0000_0002);
    cmd(`ETS_CMD_ARM);
    chk_st("auto enable", 4'b0010);
    step(1);
    chk_st("auto trigger", 4'b0100);
    step(2);
    chk_st("delay running", 4'b0100);
    step(1);
    chk_st("delay end", 4'b1000);
    $display("test auto done");

    wr(`ETS_ADDR_DELAY, 32'h0000_0000);
    wr(`ETS_ADDR_CTRL, 32'h0000_000B);
    rd(`ETS_ADDR_CTRL, 32'h0000_00FF, 32'h0000_0008, "ctrl mode three");
    wr(`ETS_ADDR_ENA_PAT, 32'h0101_0103);
    rd(`ETS_ADDR_STATUS, 32'h0000_0030, 32'h0000_0020, "emode comb");
    PRB.drive(1'b0, 8'hFD, 4'h0);
    cmd(`ETS_CMD_ARM);
    step(3);
    chk_st("qualifier low", 4'b0001);
    PRB.drive(1'b1, 8'h01, 4'h0);
    step(1);
    chk_st("enable match", 4'b0010);
    step(3);
    chk_st("manual trigger wait", 4'b0010);
    cmd(`ETS_CMD_MAN_TRG);
    wait_st("manual trigger", 4'b1000, 4);
    $display("test comb enable done");

    PRB.drive(1'b0, 8'h00, 4'h0);
    cmd(`ETS_CMD_ARM);
    chk_st("override wait", 4'b0001);
    cmd(`ETS_CMD_MAN_EN);
    wait_st("override", 4'b0010, 3);
    rd(`ETS_ADDR_STATUS, 32'h0000_0030, 32'h0000_0010, "emode kept");
    cmd(`ETS_CMD_ARM);
    PRB.drive(1'b1, 8'h01, 4'h0);
    step(2);
    chk_st("manual ignores match", 4'b0001);
    cmd(`ETS_CMD_MAN_EN);
    wait_st("manual enable", 4'b0010, 3);
    cmd(`ETS_CMD_MAN_TRG);
    wait_st("manual done", 4'b1000, 4);
    $display("test manual done");

    wr(`ETS_ADDR_DELAY, 32'h0000_0008);
    wr(`ETS_ADDR_CTRL, 32'h0000_0006);
    wr(`ETS_ADDR_ENA_PAT, 32'h0005_000F);
    PRB.drive(1'b0, 8'h00, 4'h0);
    cmd(`ETS_CMD_ARM);
    step(2);
    chk_st("false no pattern", 4'b0001);
    PRB.drive(1'b0, 8'h05, 4'h0);
    step(2);
    chk_st("false pattern found", 4'b0001);
    PRB.drive(1'b0, 8'h85, 4'h0);
    step(2);
    chk_st("false ignored bit", 4'b0001);
    PRB.drive(1'b0, 8'h04, 4'h0);
    wait_st("false fires", 4'b0100, 3);
    $display("test false enable done");

    wr(`ETS_ADDR_CTRL, 32'h0000_0050);
    wr(`ETS_ADDR_TRG_PAT, 32'h01A5_01FF);
    PRB.drive(1'b1, 8'h00, 4'h0);
    cmd(`ETS_CMD_ARM);
    chk_st("filter arm", 4'b0010);
    PRB.drive(1'b1, 8'hA5, 4'h0);
    step(1);
    PRB.drive(1'b1, 8'h00, 4'h0);
    step(3);
    chk_st("two samples", 4'b0010);
    PRB.drive(1'b1, 8'hA5, 4'h0);
    step(2);
    chk_st("filter pending", 4'b0010);
    step(1);
    chk_st("filter fires", 4'b0100);
    $display("test filter done");

    wr(`ETS_ADDR_CHSEL, 32'h0000_00FE);
    wr(`ETS_ADDR_CTRL, 32'h0000_0010);
    PRB.drive(1'b1, 8'hA4, 4'h0);
    cmd(`ETS_CMD_ARM);
    step(3);
    chk_st("standing match", 4'b0010);
    PRB.drive(1'b1, 8'h00, 4'h0);
    step(1);
    PRB.drive(1'b1, 8'hA4, 4'h0);
    step(1);
    chk_st("true trigger", 4'b0100);
    wr(`ETS_ADDR_CTRL, 32'h0000_0030);
    cmd(`ETS_CMD_ARM);
    step(2);
    chk_st("false standing", 4'b0010);
    PRB.drive(1'b1, 8'h00, 4'h0);
    step(1);
    chk_st("false trigger", 4'b0100);
    $display("test edge trigger done");

    wr(`ETS_ADDR_CHSEL, 32'h0000_00FF);
    for (int s = 0; s < 2; s++)
    begin
      wr(`ETS_ADDR_CTRL, 32'h0000_0018 | (32'(s) << 5));
      PRB.drive(1'b1, 8'h00, (s == 1) ? 4'h8 : 4'h0);
      cmd(`ETS_CMD_ARM);
      step(2);
      chk_st("analog wait", 4'b0010);
      PRB.drive(1'b1, 8'h00, (s == 1) ? 4'h0 : 4'h8);
      step(1);
      chk_st("analog fires", 4'b0100);
    end
    wr(`ETS_ADDR_CTRL, 32'h0000_0090);
    PRB.drive(1'b1, 8'h00, 4'h0);
    cmd(`ETS_CMD_ARM);
    step(1);
    chk_st("analog comb wait", 4'b0010);
    PRB.drive(1'b1, 8'hA0, 4'h0);
    step(1);
    chk_st("analog comb fires", 4'b0100);
    $display("test analog done");

    wr(`ETS_ADDR_DELAY, 32'h0001_0002);
    wr(`ETS_ADDR_CTRL, 32'h0000_0010);
    PRB.drive(1'b1, 8'h00, 4'h0);
    cmd(`ETS_CMD_ARM);
    for (int p = 0; p < 3; p++)
    begin
      PRB.drive(1'b1, 8'hA5, 4'h0);
      PRB.drive(1'b1, 8'h00, 4'h0);
      step(3);
      if (p == 0)
        chk_st("event delay holds", 4'b0100);
    end
    chk_st("event delay end", 4'b1000);
    $display("test event delay done");
    complete_run();
  end
endmodule : tb_top
